// file: logic/motion_option_pkg.sv
/*
 * Constants, register indices and carrier types for the motion option flags block.
 * Assumes a 100 MHz system clock; the register indices are a local choice.
 */
package motion_option_pkg;

	// Timing
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned CLK_PERIOD_PS = 10000;
	localparam int unsigned SAMPLE_TIME_PS = 5400000; // 5.4 us per input sample
	localparam int unsigned SAMPLE_CYC = (SAMPLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CHOP_NORM_HZ = 20000;
	localparam int unsigned CHOP_FAST_HZ = 40000;
	localparam int unsigned CHOP_NORM_CYC = CLK_HZ / CHOP_NORM_HZ;
	localparam int unsigned CHOP_FAST_CYC = CLK_HZ / CHOP_FAST_HZ;

	// Register indices on the command port
	localparam logic [7:0] REG_AUTO_REPORT = 8'h23;
	localparam logic [7:0] REG_AXIS_CHOP = 8'h24;
	localparam logic [7:0] REG_IRQ_FILTER = 8'h25;
	localparam logic [7:0] REG_LIMIT_MODE = 8'h26;
	localparam logic [7:0] REG_MISC_ALARM = 8'h27;
	localparam logic [7:0] REG_SOFT_LIMIT = 8'h28;
	localparam logic [7:0] REG_LOWER_BOUND = 8'h8e;
	localparam logic [7:0] REG_UPPER_BOUND = 8'h8f;
	localparam logic [7:0] REG_RUN_STATUS = 8'hf0;
	localparam logic [7:0] REG_ACTUAL_POS = 8'hf1;
	localparam logic [7:0] REG_ERROR_BITS = 8'hf2;

	// Reset values
	localparam logic [7:0] RST_AXIS_CHOP = 8'h01;
	localparam logic [7:0] RST_ZERO8 = 8'h00;
	localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;

	// Field positions
	localparam int unsigned AXIS_INT_BIT = 0;
	localparam int unsigned AXIS_EXT_BIT = 1;
	localparam int unsigned CHOP_FAST_BIT = 7;
	localparam int unsigned ALARM_STOP_BIT = 0;
	localparam int unsigned AUTO_RS_BIT = 3;
	localparam int unsigned ERR_LIMIT_ACT = 11;
	localparam int unsigned ERR_LIMIT_IGN = 12;
	localparam int unsigned ERR_SOFT_POS = 13;

	// Mode encodings
	localparam logic [1:0] AXIS_BOTH = 2'h3;
	localparam logic [7:0] LIM_MODE_PLAIN = 8'h00;
	localparam logic [7:0] LIM_MODE_ACT = 8'h01;
	localparam logic [7:0] LIM_MODE_IGN = 8'h02;
	localparam logic [7:0] LIM_MODE_EITHER = 8'h03;
	localparam logic [7:0] LIM_MODE_DIR = 8'h04;
	localparam logic [7:0] SPL_OFF = 8'h00;
	localparam logic [7:0] SPL_CLAMP = 8'h01;
	localparam logic [7:0] SPL_REJECT = 8'h02;
	localparam logic [7:0] SPL_HALT = 8'h03;

	// Run status values
	localparam logic [7:0] RS_IDLE = 8'h00;
	localparam logic [7:0] RS_RUNNING = 8'h01;
	localparam logic [7:0] RS_LIMIT = 8'h07;

	typedef struct packed {
		logic [7:0] sel;
		logic [31:0] data;
	} cfg_wr_t;

	typedef struct packed {
		logic pos;
		logic neg;
		logic [2:0] user;
	} irq_in_t;

	typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

endpackage : motion_option_pkg

// file: logic/input_sample_filter.sv
/*
 * One interrupt input filter: the input must be seen active on a given number
 * of consecutive sample ticks. Assumes i_level is already synchronised.
 */
`timescale 1ns/1ps
module input_sample_filter (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Sampling
	input wire logic i_level,
	input wire logic i_tick,
	input wire logic [7:0] i_count,
	// Result
	output logic o_level
);

	logic [7:0] hits_q;

	// Hits saturate at the count so a lowered count takes effect at once
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hits_q <= 8'h00;
		end else if (!i_level) begin
			hits_q <= 8'h00;
		end else if (i_tick && (hits_q < i_count)) begin
			hits_q <= hits_q + 8'h01; // [RULE6]
		end
	end

	// A count of zero passes the input at once, without waiting for a sample tick
	assign o_level = i_level && (hits_q >= i_count); // [RULE5] [RULE6]

	direct_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE5]
		(i_count == 8'h00) |-> (o_level == i_level))
		else $error("zero count filter did not pass input");

	needs_samples_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE6]
		$rose(i_level) && (i_count > 8'h00) |-> !o_level)
		else $error("filter acted before sampling");

endmodule : input_sample_filter

// file: logic/motion_option_flags.sv
/*
 * Motion option flags: axis and chopper selection, interrupt input filtering,
 * limit run status, motor alarm stop and software position limits.
 * Assumes the command interpreter delivers one-cycle command strobes on i_clk_sys
 * and that all pin inputs are asynchronous.
 */
`timescale 1ns/1ps

// Behaviour
// [RULE1] Internal only: no external pulse or direction
// [RULE2] External only: pulses only on external connector
// [RULE3] Both axes driven in full synchronism
// [RULE4] Bit 7 doubles chopper rate to 40kHz
// [RULE5] Filter count zero acts on one sample; the filter passes the input at once, without a sample tick
// [RULE6] Count 1-255 samples, each about 5.4us
// [RULE7] Filtering covers user and limit inputs only
// [RULE8] High-speed triggers bypass filtering
// [RULE9] Either limit always stops the motor
// [RULE10] Mode 0: limit stop gives status 0
// [RULE11] Modes 1-3: status 7 on chosen errors
// [RULE12] Mode 4: status 7 on same-direction limit
// [RULE13] Clear or new run clears limit error
// [RULE14] Alarm normally checked only before a run
// [RULE15] Alarm bit plus report bit: immediate halt
// [RULE16] Alarm bit: status read also stops
// [RULE17] Alarm stop equals immediate stop command
// [RULE18] Soft limit mode 0: no check
// [RULE19] Mode 1: clamp, error 13, flash once
// [RULE20] Mode 2: reject move, set error 13
// [RULE21] Mode 3: reject and halt program
// [RULE22] Report bit: status, position once per line
// [RULE23] Lower bound is minimum, upper maximum
module motion_option_flags
	import motion_option_pkg::*;
#(
	parameter int unsigned CHOP_NORM_PERIOD = CHOP_NORM_CYC,
	parameter int unsigned CHOP_FAST_PERIOD = CHOP_FAST_CYC,
	parameter int unsigned STEP_PERIOD = 1000
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Register command port
	input wire logic i_cfg_wr,
	input wire cfg_wr_t i_cfg,
	input wire logic i_cfg_rd,
	input wire logic [7:0] i_cfg_rd_sel,
	output logic [31:0] o_rd_data_q,
	// Program commands
	input wire logic i_run_cmd,
	input wire logic [31:0] i_run_target,
	input wire logic i_stop_cmd,
	input wire logic i_err_clear_cmd,
	input wire logic i_status_read_cmd,
	input wire logic i_line_exec,
	// Pins
	input wire logic [2:0] i_user_in,
	input wire logic i_neg_limit,
	input wire logic i_pos_limit,
	input wire logic i_hs_start,
	input wire logic i_hs_stop,
	input wire logic i_motor_alarm,
	// Axis outputs
	output logic o_int_drv_en_q,
	output logic o_int_step_q,
	output logic o_int_dir_q,
	output logic o_ext_step_q,
	output logic o_ext_dir_q,
	output logic o_chopper_q,
	// Inputs towards the program
	output irq_in_t o_irq_in_q,
	output logic o_hs_start_q,
	output logic o_hs_stop_q,
	// Status
	output logic [7:0] o_run_status_q,
	output logic [31:0] o_actual_pos_q,
	output logic [15:0] o_err_bits_q,
	output logic o_err_flash_q,
	output logic o_prog_halt_q,
	output logic o_report_q,
	output logic [7:0] o_report_status_q,
	output logic [31:0] o_report_pos_q
);

	localparam int unsigned NPIN = 8;
	localparam int unsigned NFILT = 5;
	localparam int unsigned PIN_HS_START = 5;
	localparam int unsigned PIN_HS_STOP = 6;
	localparam int unsigned PIN_ALARM = 7;
	localparam logic [31:0] ONE32 = 32'h0000_0001;
	localparam logic [12:0] CHOP_NORM_HALF = 13'(CHOP_NORM_PERIOD / 2);
	localparam logic [12:0] CHOP_FAST_HALF = 13'(CHOP_FAST_PERIOD / 2);
	localparam logic [9:0] SAMPLE_LAST = 10'(SAMPLE_CYC - 1);
	localparam logic [15:0] STEP_LAST = 16'(STEP_PERIOD - 1);

	logic [7:0] axis_q, filt_cnt_q, lim_mode_q, misc_q, spl_mode_q, auto_q;
	logic [31:0] lower_q, upper_q;
	logic [NPIN-1:0] pin_meta_q, pin_q;
	logic [9:0] sample_cnt_q;
	logic sample_tick;
	logic [NFILT-1:0] filt_lvl;
	irq_in_t filt;
	logic [1:0] lim_prev_q;
	logic [12:0] chop_cnt_q;
	logic [12:0] chop_half;
	run_state_t state_q;
	logic [31:0] target_q;
	logic dir_q;
	logic [15:0] step_cnt_q;
	logic step_tick;
	logic dir_hit_q;
	logic [7:0] rs_d;

	// Command events
	logic alarm, lim_any, lim_rise, lim_stop, lim_dir_hit;
	logic run_take, run_ok, out_lo, out_hi, violate;
	logic spl_clamp, spl_reject, run_start, alarm_halt, halt_stop;
	logic [31:0] eff_target;

	// Configuration registers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			axis_q <= RST_AXIS_CHOP;
			filt_cnt_q <= RST_ZERO8;
			lim_mode_q <= RST_ZERO8;
			misc_q <= RST_ZERO8;
			spl_mode_q <= RST_ZERO8;
			auto_q <= RST_ZERO8;
			lower_q <= RST_ZERO32;
			upper_q <= RST_ZERO32;
		end else if (i_cfg_wr) begin
			case (i_cfg.sel)
				REG_AXIS_CHOP: axis_q <= i_cfg.data[7:0];
				REG_IRQ_FILTER: filt_cnt_q <= i_cfg.data[7:0];
				REG_LIMIT_MODE: lim_mode_q <= i_cfg.data[7:0];
				REG_MISC_ALARM: misc_q <= i_cfg.data[7:0];
				REG_SOFT_LIMIT: spl_mode_q <= i_cfg.data[7:0];
				REG_AUTO_REPORT: auto_q <= i_cfg.data[7:0];
				REG_LOWER_BOUND: lower_q <= i_cfg.data;
				REG_UPPER_BOUND: upper_q <= i_cfg.data;
				default: ;
			endcase
		end
	end

	// Read port; unmapped indices read as zero
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data_q <= RST_ZERO32;
		end else if (i_cfg_rd) begin
			case (i_cfg_rd_sel)
				REG_AXIS_CHOP: o_rd_data_q <= {24'h000000, axis_q};
				REG_IRQ_FILTER: o_rd_data_q <= {24'h000000, filt_cnt_q};
				REG_LIMIT_MODE: o_rd_data_q <= {24'h000000, lim_mode_q};
				REG_MISC_ALARM: o_rd_data_q <= {24'h000000, misc_q};
				REG_SOFT_LIMIT: o_rd_data_q <= {24'h000000, spl_mode_q};
				REG_AUTO_REPORT: o_rd_data_q <= {24'h000000, auto_q};
				REG_LOWER_BOUND: o_rd_data_q <= lower_q;
				REG_UPPER_BOUND: o_rd_data_q <= upper_q;
				REG_RUN_STATUS: o_rd_data_q <= {24'h000000, o_run_status_q};
				REG_ACTUAL_POS: o_rd_data_q <= o_actual_pos_q;
				REG_ERROR_BITS: o_rd_data_q <= {16'h0000, o_err_bits_q};
				default: o_rd_data_q <= RST_ZERO32;
			endcase
		end
	end

	// Pin synchronisers
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta_q <= '0;
			pin_q <= '0;
		end else begin
			pin_meta_q <= {i_motor_alarm, i_hs_stop, i_hs_start, i_pos_limit, i_neg_limit, i_user_in};
			pin_q <= pin_meta_q;
		end
	end

	// Sample clock for the interrupt filters
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sample_cnt_q <= 10'h000;
		end else if (sample_tick) begin
			sample_cnt_q <= 10'h000;
		end else begin
			sample_cnt_q <= sample_cnt_q + 10'h001;
		end
	end
	assign sample_tick = (sample_cnt_q == SAMPLE_LAST); // [RULE6]

	// Only user and limit inputs get a filter
	for (genvar g = 0; g < NFILT; g++) begin : g_filt // [RULE7]
		input_sample_filter u_filt (
			.i_clk_sys(i_clk_sys),
			.i_rst_n(i_rst_n),
			.i_level(pin_q[g]),
			.i_tick(sample_tick),
			.i_count(filt_cnt_q),
			.o_level(filt_lvl[g])
		);
	end
	assign filt = irq_in_t'(filt_lvl);

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq_in_q <= '0;
			o_hs_start_q <= 1'b0;
			o_hs_stop_q <= 1'b0;
			lim_prev_q <= 2'h0;
		end else begin
			o_irq_in_q <= filt;
			o_hs_start_q <= pin_q[PIN_HS_START]; // [RULE8]
			o_hs_stop_q <= pin_q[PIN_HS_STOP]; // [RULE8]
			lim_prev_q <= {filt.pos, filt.neg};
		end
	end

	// Chopper; a rate change also applies to the half period in progress
	assign chop_half = axis_q[CHOP_FAST_BIT] ? CHOP_FAST_HALF : CHOP_NORM_HALF; // [RULE4]
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chop_cnt_q <= 13'h0000;
			o_chopper_q <= 1'b0;
		end else if (chop_cnt_q >= chop_half - 13'h0001) begin
			chop_cnt_q <= 13'h0000;
			o_chopper_q <= ~o_chopper_q; // [RULE4]
		end else begin
			chop_cnt_q <= chop_cnt_q + 13'h0001;
		end
	end

	always_comb begin
		alarm = pin_q[PIN_ALARM];
		lim_any = filt.neg | filt.pos;
		lim_rise = (filt.neg & ~lim_prev_q[0]) | (filt.pos & ~lim_prev_q[1]);
		lim_stop = (state_q == ST_RUN) && lim_rise; // [RULE9]
		lim_dir_hit = lim_stop && ((dir_q && filt.pos && !lim_prev_q[1])
			|| (!dir_q && filt.neg && !lim_prev_q[0])); // [RULE12]
		// Alarm is only looked at when a run is asked for, unless enabled below
		run_take = (state_q == ST_IDLE) && i_run_cmd;
		run_ok = run_take && !alarm && !lim_any; // [RULE14]
		out_lo = $signed(i_run_target) < $signed(lower_q); // [RULE23]
		out_hi = $signed(i_run_target) > $signed(upper_q); // [RULE23]
		violate = (spl_mode_q != SPL_OFF) && (out_lo || out_hi); // [RULE18]
		spl_clamp = run_ok && violate && (spl_mode_q == SPL_CLAMP); // [RULE19]
		spl_reject = run_ok && violate && (spl_mode_q >= SPL_REJECT); // [RULE20] [RULE21]
		eff_target = i_run_target;
		if (spl_clamp) begin
			eff_target = out_lo ? lower_q : upper_q; // [RULE19]
		end
		run_start = run_ok && !spl_reject && (eff_target != o_actual_pos_q);
		alarm_halt = misc_q[ALARM_STOP_BIT] && alarm
			&& (auto_q[AUTO_RS_BIT] || i_status_read_cmd); // [RULE15] [RULE16]
		halt_stop = (state_q == ST_RUN) && (i_stop_cmd || alarm_halt); // [RULE17]
	end

	// Motion sequencer
	assign step_tick = (state_q == ST_RUN) && (step_cnt_q == STEP_LAST);
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			target_q <= RST_ZERO32;
			dir_q <= 1'b0;
			step_cnt_q <= 16'h0000;
			o_actual_pos_q <= RST_ZERO32;
		end else begin
			case (state_q)
				ST_IDLE: begin
					step_cnt_q <= 16'h0000;
					if (run_start) begin
						state_q <= ST_RUN;
						target_q <= eff_target;
						dir_q <= $signed(eff_target) > $signed(o_actual_pos_q);
					end
				end
				ST_RUN: begin
					step_cnt_q <= step_tick ? 16'h0000 : step_cnt_q + 16'h0001;
					if (lim_stop || halt_stop) begin
						state_q <= ST_IDLE; // [RULE9] [RULE17]
					end else if (step_tick) begin
						o_actual_pos_q <= dir_q ? o_actual_pos_q + ONE32 : o_actual_pos_q - ONE32;
						if ((dir_q ? o_actual_pos_q + ONE32 : o_actual_pos_q - ONE32) == target_q) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Same step tick feeds both axes, so both run in lock step
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_int_drv_en_q <= 1'b0;
			o_int_step_q <= 1'b0;
			o_int_dir_q <= 1'b0;
			o_ext_step_q <= 1'b0;
			o_ext_dir_q <= 1'b0;
		end else begin
			o_int_drv_en_q <= axis_q[AXIS_INT_BIT]; // [RULE1]
			o_int_step_q <= step_tick && !lim_stop && !halt_stop && axis_q[AXIS_INT_BIT]; // [RULE3]
			o_int_dir_q <= dir_q && axis_q[AXIS_INT_BIT]; // [RULE2]
			o_ext_step_q <= step_tick && !lim_stop && !halt_stop && axis_q[AXIS_EXT_BIT]; // [RULE3]
			o_ext_dir_q <= dir_q && axis_q[AXIS_EXT_BIT]; // [RULE1]
		end
	end

	// Error flags; a setting event wins over a clear in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_err_bits_q <= 16'h0000;
			dir_hit_q <= 1'b0;
		end else begin
			if (lim_stop) begin
				o_err_bits_q[ERR_LIMIT_ACT] <= 1'b1;
			end else if (i_err_clear_cmd || run_take) begin
				o_err_bits_q[ERR_LIMIT_ACT] <= 1'b0; // [RULE13]
			end
			if (lim_dir_hit) begin
				dir_hit_q <= 1'b1;
			end else if (i_err_clear_cmd || run_take) begin
				dir_hit_q <= 1'b0; // [RULE13]
			end
			if (run_take && lim_any && !alarm) begin
				o_err_bits_q[ERR_LIMIT_IGN] <= 1'b1;
			end else if (i_err_clear_cmd) begin
				o_err_bits_q[ERR_LIMIT_IGN] <= 1'b0;
			end
			if (spl_clamp || spl_reject) begin
				o_err_bits_q[ERR_SOFT_POS] <= 1'b1; // [RULE19] [RULE20]
			end else if (i_err_clear_cmd) begin
				o_err_bits_q[ERR_SOFT_POS] <= 1'b0;
			end
		end
	end

	// Run status as seen by the program
	always_comb begin
		rs_d = RS_IDLE; // [RULE10]
		if (state_q == ST_RUN) begin
			rs_d = RS_RUNNING;
		end else begin
			case (lim_mode_q)
				LIM_MODE_ACT: if (o_err_bits_q[ERR_LIMIT_ACT]) rs_d = RS_LIMIT; // [RULE11]
				LIM_MODE_IGN: if (o_err_bits_q[ERR_LIMIT_IGN]) rs_d = RS_LIMIT; // [RULE11]
				LIM_MODE_EITHER: if (o_err_bits_q[ERR_LIMIT_ACT] || o_err_bits_q[ERR_LIMIT_IGN])
					rs_d = RS_LIMIT; // [RULE11]
				LIM_MODE_DIR: if (dir_hit_q) rs_d = RS_LIMIT; // [RULE12]
				default: rs_d = RS_IDLE;
			endcase
		end
	end

	// Status, halt and report outputs
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_run_status_q <= RS_IDLE;
			o_err_flash_q <= 1'b0;
			o_prog_halt_q <= 1'b0;
			o_report_q <= 1'b0;
			o_report_status_q <= RS_IDLE;
			o_report_pos_q <= RST_ZERO32;
		end else begin
			o_run_status_q <= rs_d;
			o_err_flash_q <= spl_clamp; // [RULE19]
			o_prog_halt_q <= alarm_halt || (spl_reject && (spl_mode_q == SPL_HALT)); // [RULE15] [RULE21]
			o_report_q <= i_line_exec && auto_q[AUTO_RS_BIT]; // [RULE22]
			if (i_line_exec && auto_q[AUTO_RS_BIT]) begin
				o_report_status_q <= rs_d; // [RULE22]
				o_report_pos_q <= o_actual_pos_q;
			end
		end
	end

	ext_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE1]
		!axis_q[AXIS_EXT_BIT] |=> !o_ext_step_q && !o_ext_dir_q)
		else $error("external axis active while deselected");
	int_quiet_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE2]
		!axis_q[AXIS_INT_BIT] |=> !o_int_step_q && !o_int_dir_q && !o_int_drv_en_q)
		else $error("internal driver active while deselected");
	step_sync_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE3]
		axis_q[1:0] == AXIS_BOTH |=> (o_int_step_q == o_ext_step_q) && (o_int_dir_q == o_ext_dir_q))
		else $error("axes out of step");
	chop_toggle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE4]
		(chop_cnt_q == chop_half - 13'h0001) |=> $changed(o_chopper_q))
		else $error("chopper missed its half period");
	limit_stop_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE9]
		lim_stop |=> (state_q == ST_IDLE) && o_err_bits_q[ERR_LIMIT_ACT])
		else $error("limit did not stop the motor");
	rs_plain_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE10]
		(lim_mode_q == LIM_MODE_PLAIN) && (state_q == ST_IDLE) |=> o_run_status_q == RS_IDLE)
		else $error("mode 0 status not zero after stop");
	rs_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE12]
		lim_dir_hit ##1 (lim_mode_q == LIM_MODE_DIR) |=> o_run_status_q == RS_LIMIT)
		else $error("direction limit status not 7");
	clear_e11_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE13]
		i_err_clear_cmd && !lim_stop |=> !o_err_bits_q[ERR_LIMIT_ACT] ##1 o_run_status_q != RS_LIMIT
			|| lim_mode_q == LIM_MODE_IGN || lim_mode_q == LIM_MODE_EITHER)
		else $error("limit error not cleared");
	alarm_halt_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE15]
		misc_q[ALARM_STOP_BIT] && auto_q[AUTO_RS_BIT] && alarm && (state_q == ST_RUN)
			|=> (state_q == ST_IDLE) && o_prog_halt_q)
		else $error("alarm did not halt motor and program");
	spl_reject_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE20]
		spl_reject |=> (state_q == ST_IDLE) && o_err_bits_q[ERR_SOFT_POS])
		else $error("out of range move was executed");
	spl_clamp_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // [RULE19]
		spl_clamp && run_start |=> o_err_flash_q && ($signed(target_q) >= $signed(lower_q))
			&& ($signed(target_q) <= $signed(upper_q)))
		else $error("clamped target outside bounds");

	run_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
		run_start ##[1:1000] (state_q == ST_IDLE));
	limit_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) lim_dir_hit);
	clamp_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) spl_clamp);
	alarm_cov_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) halt_stop && alarm);

endmodule : motion_option_flags

// file: tb/ext_driver_model.sv
/*
 * Model of an outside step or servo driver on the external axis connector.
 * Assumes one-cycle step pulses and a level direction signal from the block.
 */
`timescale 1ns/1ps
module ext_driver_model (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Axis from the block
	input wire logic i_step,
	input wire logic i_dir,
	// Fault request from the bench
	input wire logic i_fault,
	// Towards the block and bench
	output logic o_alarm,
	output int o_pos
);
	// Alarm is a plain level; a real drive holds it until its fault clears
	assign o_alarm = i_fault;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pos <= 0;
		end else if (i_step) begin
			o_pos <= i_dir ? o_pos + 1 : o_pos - 1;
		end
	end
endmodule : ext_driver_model

// file: tb/tb_motion_option_flags.sv
/*
 * Self-checking bench for the motion option flags block.
 * Assumes the package, the block and the external driver model compile first.
 */
`timescale 1ns/1ps
module tb_motion_option_flags;
	import motion_option_pkg::*;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, run = 0, stp = 0, clr = 0, srd = 0, lx = 0;
	logic nl = 0, pl = 0, hs0 = 0, hs1 = 0, flt = 0, alarm;
	cfg_wr_t cfg = '0;
	logic [7:0] rsel = '0, rs, rrs;
	logic [31:0] tgt = '0, rdq, apos, p, rpos;
	logic [2:0] usr = '0;
	logic [15:0] eb;
	logic istep, idir, estep, edir, ien, chop, flash, halt, rep, hss, hsp;
	irq_in_t irq;
	int fail_count = 0, samples_checked = 0, cyc = 0, isteps = 0, epos, t0;
	logic flash_seen = 0, halt_seen = 0, rep_seen = 0;
	int lm[5] = '{0, 1, 3, 4, 4};
	logic lp[5] = '{1, 1, 0, 0, 1};
	logic [7:0] ls[5] = '{8'h00, 8'h07, 8'h07, 8'h00, 8'h07};

	// Short periods keep the run brief; expectations follow these values
	motion_option_flags #(.CHOP_NORM_PERIOD(20), .CHOP_FAST_PERIOD(10), .STEP_PERIOD(4)) uut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg_wr(wr), .i_cfg(cfg), .i_cfg_rd(rd),
		.i_cfg_rd_sel(rsel), .o_rd_data_q(rdq), .i_run_cmd(run), .i_run_target(tgt),
		.i_stop_cmd(stp), .i_err_clear_cmd(clr), .i_status_read_cmd(srd), .i_line_exec(lx),
		.i_user_in(usr), .i_neg_limit(nl), .i_pos_limit(pl), .i_hs_start(hs0),
		.i_hs_stop(hs1), .i_motor_alarm(alarm), .o_int_drv_en_q(ien), .o_int_step_q(istep),
		.o_int_dir_q(idir), .o_ext_step_q(estep), .o_ext_dir_q(edir), .o_chopper_q(chop),
		.o_irq_in_q(irq), .o_hs_start_q(hss), .o_hs_stop_q(hsp), .o_run_status_q(rs),
		.o_actual_pos_q(apos), .o_err_bits_q(eb), .o_err_flash_q(flash), .o_prog_halt_q(halt),
		.o_report_q(rep), .o_report_status_q(rrs), .o_report_pos_q(rpos));
	ext_driver_model drv (.i_clk_sys(clk), .i_rst_n(rst_n), .i_step(estep), .i_dir(edir),
		.i_fault(flt), .o_alarm(alarm), .o_pos(epos));

	initial begin
		forever #5 clk = ~clk;
	end

	// One-cycle pulses are latched here so a sequence can look at them later
	always @(posedge clk) begin
		cyc++;
		if (istep === 1'b1) isteps++;
		if (flash === 1'b1) flash_seen = 1;
		if (halt === 1'b1) halt_seen = 1;
		if (rep === 1'b1) rep_seen = 1;
		if (cyc == 30000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] s, input logic [31:0] d);
		@(negedge clk);
		wr = 1;
		cfg = '{sel: s, data: d};
		@(negedge clk);
		wr = 0;
	endtask : wreg

	task automatic rc(input string n, input logic [7:0] s, input logic [31:0] e);
		@(negedge clk);
		rd = 1;
		rsel = s;
		@(negedge clk);
		rd = 0;
		@(negedge clk);
		chk(n, rdq, e);
	endtask : rc

	task automatic start(input logic [31:0] t);
		@(negedge clk);
		run = 1;
		tgt = t;
		@(negedge clk);
		run = 0;
		repeat (3) @(negedge clk);
	endtask : start

	task automatic go(input logic [31:0] t);
		start(t);
		for (int i = 0; i < 3000 && rs === RS_RUNNING; i++) @(negedge clk);
	endtask : go

	task automatic clear();
		@(negedge clk);
		clr = 1;
		@(negedge clk);
		clr = 0;
		repeat (2) @(negedge clk);
	endtask : clear

	task automatic per(output int n);
		realtime t;
		@(posedge chop);
		t = $realtime;
		@(posedge chop);
		n = int'(($realtime - t) / 10.0);
	endtask : per

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		chk("drv_en", ien, 1);
		rc("axis", REG_AXIS_CHOP, 32'h01);
		rc("limmode", REG_LIMIT_MODE, 32'h00);
		rc("softmode", REG_SOFT_LIMIT, 32'h00);
		rc("unmapped", 8'h55, 32'h00);
		wreg(REG_AXIS_CHOP, 32'h02);
		go(32'h03);
		chk("ext_pos", epos, 3);
		chk("int_steps", isteps, 0);
		chk("int_en", ien, 0);
		chk("int_dir", idir, 0);
		wreg(REG_AXIS_CHOP, 32'h01);
		go(32'h00);
		chk("ext_pos", epos, 3);
		chk("int_steps", isteps, 3);
		wreg(REG_AXIS_CHOP, 32'h03);
		go(32'h02);
		chk("ext_pos", epos, 5);
		chk("int_steps", isteps, 5);
		rc("pos", REG_ACTUAL_POS, 32'h02);
		chk("both_dir", {idir, edir}, 2'h3);
		per(t0);
		chk("chop_norm", t0, 20);
		wreg(REG_AXIS_CHOP, 32'h83);
		go(32'h04);
		per(t0);
		chk("chop_fast", t0, 10);
		chk("both_fast", epos + isteps, 14);
		foreach (lm[i]) begin
			wreg(REG_LIMIT_MODE, lm[i]);
			start(apos + 32'h32);
			chk("e11_new", eb[ERR_LIMIT_ACT], 0);
			{pl, nl} = lp[i] ? 2'h2 : 2'h1;
			repeat (8) @(negedge clk);
			chk("lim_rs", rs, ls[i]);
			chk("e11", eb[ERR_LIMIT_ACT], 1);
			{pl, nl} = 2'h0;
			// Even passes leave the error set so the next run has to clear it
			if (i % 2 == 1) begin
				clear();
				chk("clr_rs", rs, RS_IDLE);
			end
		end
		wreg(REG_LIMIT_MODE, LIM_MODE_IGN);
		pl = 1;
		repeat (4) @(negedge clk);
		start(apos + 32'h32);
		chk("e12", eb[ERR_LIMIT_IGN], 1);
		chk("ign_rs", rs, RS_LIMIT);
		pl = 0;
		clear();
		p = apos;
		wreg(REG_LOWER_BOUND, 32'h00);
		wreg(REG_UPPER_BOUND, p + 32'h05);
		wreg(REG_SOFT_LIMIT, SPL_REJECT);
		go(p + 32'h14);
		chk("reject", apos, p);
		chk("e13", eb[ERR_SOFT_POS], 1);
		wreg(REG_SOFT_LIMIT, SPL_CLAMP);
		go(p + 32'h14);
		chk("clamp", apos, p + 32'h05);
		chk("flash", flash_seen, 1);
		wreg(REG_SOFT_LIMIT, SPL_HALT);
		go(p + 32'h32);
		chk("halt", halt_seen, 1);
		chk("halt_pos", apos, p + 32'h05);
		wreg(REG_SOFT_LIMIT, SPL_OFF);
		go(p + 32'h09);
		chk("no_check", apos, p + 32'h09);
		start(apos + 32'h64);
		flt = 1;
		repeat (10) @(negedge clk);
		chk("alm_dflt", rs, RS_RUNNING);
		wreg(REG_MISC_ALARM, 32'h01);
		repeat (4) @(negedge clk);
		chk("alm_norpt", rs, RS_RUNNING);
		@(negedge clk);
		srd = 1;
		@(negedge clk);
		srd = 0;
		repeat (4) @(negedge clk);
		chk("alm_read", rs, RS_IDLE);
		flt = 0;
		halt_seen = 0;
		wreg(REG_AUTO_REPORT, 32'h08);
		start(apos + 32'h64);
		flt = 1;
		repeat (6) @(negedge clk);
		chk("alm_stop", rs, RS_IDLE);
		chk("alm_halt", halt_seen, 1);
		flt = 0;
		@(negedge clk);
		lx = 1;
		@(negedge clk);
		lx = 0;
		repeat (3) @(negedge clk);
		chk("report", rep_seen, 1);
		chk("rep_pos", rpos, apos);
		chk("rep_rs", rrs, RS_IDLE);
		start(apos + 32'h64);
		stp = 1;
		@(negedge clk);
		stp = 0;
		repeat (3) @(negedge clk);
		chk("stop_cmd", rs, RS_IDLE);
		wreg(REG_IRQ_FILTER, 32'h03);
		usr = 3'h1;
		{pl, hs0, hs1} = 3'h7;
		repeat (100) @(negedge clk);
		chk("hs_direct", {hss, hsp}, 2'h3);
		chk("flt_short", irq, 5'h00);
		repeat (2000) @(negedge clk);
		chk("flt_long", irq, 5'h11);
		wreg(REG_IRQ_FILTER, 32'h00);
		usr = 3'h2;
		repeat (5) @(negedge clk);
		chk("flt_zero", irq.user, 3'h2);
		final_report();
	end
endmodule : tb_motion_option_flags
